/* rtl/acqcc_top.sv */
// Conversion control of a byte-wide I/O acquisition card.
// Assumes host strobes synchronous to CLK_SYS, one cycle each.
`timescale 1ns/100ps

// ===============================
// Result FIFO
module acqcc_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Filling side
    input  wire logic             in_valid,
    output wire logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output wire logic             out_valid,
    input  wire logic             out_ready,
    output wire logic [WIDTH-1:0] out_data,
    output wire logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("FIFO depth must be a power of two");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;

    // Honest full and empty
    assign in_ready  = count != (AW + 1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data  = mem[rd_ptr];
    assign level     = count;

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop) count <= count + 1'b1;
            else if (pop && !push) count <= count - 1'b1;
        end
    end
endmodule

// ===============================
// Top level
module acqcc_top #(
    parameter int FIFO_DEPTH = acqcc_pkg::FIFO_DEPTH_D
) (
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    // Host I/O bus
    input  wire logic [3:0]  IO_ADDR,
    input  wire logic        IO_WR,
    input  wire logic        IO_RD,
    input  wire logic [7:0]  IO_WDATA,
    output logic      [7:0]  IO_RDATA,
    // Interrupt request lines, bit 0 is IRQ2
    output logic      [acqcc_pkg::IRQ_N-1:0] IRQ_REQ,
    // Connector lines
    input  wire logic [15:0] SAMPLED_INPUT_LINES,
    output wire logic [15:0] DRIVEN_OUTPUT_LINES,
    // Converter
    output wire logic        ADC_START,
    input  wire logic        ADC_EOC,
    input  wire logic [11:0] CONVERSION_RESULT,
    // Analog output code
    output logic      [11:0] ANALOG_OUT_CODE,
    // Pacer divisors, static configuration
    input  wire logic [15:0] PACER_DIV1,
    input  wire logic [15:0] PACER_DIV2
);
    import acqcc_pkg::*;

    localparam int BD_W = $clog2(BASE_DIV);
    localparam int TW   = $clog2(CONV_MAX_CYC);
    localparam logic [TW-1:0] CONV_LIMIT = TW'(CONV_MAX_CYC - 2);
    localparam int LW   = $clog2(FIFO_DEPTH) + 1;

    // Line code to one-hot request lines
    function automatic logic [IRQ_N-1:0] irq_decode(
        input logic [2:0] sel
    );
        irq_decode = '0;
        if (sel == IRQ_SEL_2A || sel == IRQ_SEL_2B) irq_decode[0] = 1'b1;
        else if (sel == IRQ_SEL_3) irq_decode[1] = 1'b1;
        else if (sel == IRQ_SEL_4) irq_decode[2] = 1'b1;
        else if (sel == IRQ_SEL_5) irq_decode[3] = 1'b1;
        else if (sel == IRQ_SEL_6) irq_decode[4] = 1'b1;
    endfunction

    // Divisor floor keeps the pacer at or below base / 4
    function automatic logic [15:0] clamp_div(input logic [15:0] d);
        clamp_div = (d < PACER_DIV_MIN) ? PACER_DIV_MIN : d;
    endfunction

    // ===============================
    // Registers and state
    logic [2:0]       conversion_mode_field;
    logic [2:0]       interrupt_line_select;
    logic [7:0]       out_low;
    logic [7:0]       out_high;
    logic [7:0]       ao_stage;
    logic             int_flag;
    logic             next_int_flag;
    acqcc_state_t     state;
    acqcc_state_t     next_state;
    logic [TW-1:0]    conv_timer;
    logic [15:0]      di_s1;
    logic [15:0]      di_s2;
    logic             di0_d;
    logic             eoc_s1;
    logic             eoc_s2;
    logic             eoc_s3;
    logic [11:0]      res_s1;
    logic [11:0]      res_s2;
    logic [BD_W-1:0]  base_cnt;
    logic [15:0]      pc1;
    logic [15:0]      pc2;
    wire              fifo_ready;
    wire              fifo_valid;
    wire  [11:0]      fifo_data;
    wire  [LW-1:0]    fifo_level;

    // ===============================
    // Address decode
    wire wr_int_clr = IO_WR & (IO_ADDR == OFS_INT_CLR);
    wire wr_mode    = IO_WR & (IO_ADDR == OFS_MODE);
    wire wr_strobe  = IO_WR & (IO_ADDR == OFS_STROBE);
    wire wr_out_lo  = IO_WR & (IO_ADDR == OFS_OUT_LOW);
    wire wr_out_hi  = IO_WR & (IO_ADDR == OFS_OUT_HIGH);
    wire wr_ao_lo   = IO_WR & (IO_ADDR == OFS_AO_LOW);
    wire wr_ao_hi   = IO_WR & (IO_ADDR == OFS_AO_HIGH);
    wire rd_res_lo  = IO_RD & (IO_ADDR == OFS_RES_LOW);

    // Mode classification
    wire m_ext   = (conversion_mode_field == MODE_EXT_POLL)
                 | (conversion_mode_field == MODE_EXT_INT);
    wire m_pacer = (conversion_mode_field == MODE_PACER_POLL)
                 | (conversion_mode_field == MODE_PACER_INT);
    wire m_int   = (conversion_mode_field == MODE_EXT_INT)
                 | (conversion_mode_field == MODE_PACER_INT);

    // ===============================
    // Pin synchronisers
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            di_s1  <= '0;
            di_s2  <= '0;
            di0_d  <= 1'b0;
            eoc_s1 <= 1'b0;
            eoc_s2 <= 1'b0;
            eoc_s3 <= 1'b0;
            res_s1 <= '0;
            res_s2 <= '0;
        end else begin
            di_s1  <= SAMPLED_INPUT_LINES;
            di_s2  <= di_s1;
            di0_d  <= di_s2[0];
            eoc_s1 <= ADC_EOC;
            eoc_s2 <= eoc_s1;
            eoc_s3 <= eoc_s2;
            res_s1 <= CONVERSION_RESULT;
            res_s2 <= res_s1;
        end
    end

    // Edges seen after the second stage
    wire ext_rise = di_s2[0] & ~di0_d;
    wire eoc_rise = eoc_s2 & ~eoc_s3;

    // ===============================
    // Host writable registers
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            conversion_mode_field <= MODE_RST;
            interrupt_line_select <= IRQ_RST;
            out_low  <= BYTE_RST;
            out_high <= BYTE_RST;
            ao_stage <= BYTE_RST;
            ANALOG_OUT_CODE <= '0;
        end else begin
            if (wr_mode) begin
                conversion_mode_field <= IO_WDATA[MODE_MSB:MODE_LSB];
                interrupt_line_select <= IO_WDATA[IRQ_MSB:IRQ_LSB];
            end
            if (wr_out_lo) out_low <= IO_WDATA;
            if (wr_out_hi) out_high <= IO_WDATA;
            if (wr_ao_lo) ao_stage <= IO_WDATA;
            if (wr_ao_hi) begin
                ANALOG_OUT_CODE <= {IO_WDATA[AO_HI_MSB:0], ao_stage};
            end
        end
    end

    assign DRIVEN_OUTPUT_LINES = {out_high, out_low};

    // ===============================
    // Pacer from the 2 MHz base tick
    wire        base_tick = base_cnt == BD_W'(BASE_DIV - 1);
    wire [15:0] div1m = clamp_div(PACER_DIV1) - 16'h0001;
    wire [15:0] div2m = clamp_div(PACER_DIV2) - 16'h0001;
    wire        pc1_wrap = m_pacer & base_tick & (pc1 == '0);
    wire        pacer_fire = pc1_wrap & (pc2 == '0);

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            base_cnt <= '0;
        end else begin
            base_cnt <= base_tick ? '0 : base_cnt + 1'b1;
        end
    end

    // Cascaded down counters, reloaded while no pacer mode is selected
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pc1 <= '0;
            pc2 <= '0;
        end else if (!m_pacer) begin
            pc1 <= div1m;
            pc2 <= div2m;
        end else begin
            if (base_tick) pc1 <= (pc1 == '0) ? div1m : pc1 - 1'b1;
            if (pc1_wrap) pc2 <= (pc2 == '0) ? div2m : pc2 - 1'b1;
        end
    end

    // ===============================
    // Trigger selection
    wire trig_any = wr_strobe
                  | (m_ext & ext_rise)
                  | (m_pacer & pacer_fire);
    wire trig_go  = trig_any & fifo_ready & (state == ST_IDLE);
    wire conv_end = (state == ST_WAIT)
                  & (eoc_rise | (conv_timer == CONV_LIMIT));

    // Sequencer next state
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (trig_go) next_state = ST_START;
            end
            ST_START: begin
                next_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (conv_end) next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Sequencer state and conversion timer
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            state      <= ST_IDLE;
            conv_timer <= '0;
        end else begin
            state <= next_state;
            if (state == ST_START) conv_timer <= '0;
            else if (state == ST_WAIT) conv_timer <= conv_timer + 1'b1;
        end
    end

    assign ADC_START = state == ST_START;

    // ===============================
    // Result buffer
    acqcc_fifo #(
        .WIDTH (12),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK_SYS),
        .rst_n     (RST_N),
        .in_valid  (conv_end),
        .in_ready  (fifo_ready),
        .in_data   (res_s2),
        .out_valid (fifo_valid),
        .out_ready (rd_res_lo),
        .out_data  (fifo_data),
        .level     (fifo_level)
    );

    // Ready while a result waits and nothing converts
    wire result_pending_flag = fifo_valid & (state == ST_IDLE);

    // ===============================
    // Status flag and request lines, set wins
    always_comb begin
        next_int_flag = int_flag;
        if (conv_end && m_int) next_int_flag = 1'b1;
        else if (wr_int_clr) next_int_flag = 1'b0;
    end

    wire [IRQ_N-1:0] next_irq = (int_flag && m_int)
                              ? irq_decode(interrupt_line_select)
                              : '0;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            int_flag <= 1'b0;
            IRQ_REQ  <= '0;
        end else begin
            int_flag <= next_int_flag;
            IRQ_REQ  <= next_irq;
        end
    end

    // ===============================
    // Read path; unmapped offsets read zero
    wire [7:0] rd_value =
        (IO_ADDR == OFS_RES_LOW)  ? fifo_data[7:0] :
        (IO_ADDR == OFS_RES_HIGH) ? {3'h0, result_pending_flag,
                                     fifo_data[11:8]} :
        (IO_ADDR == OFS_IN_LOW)   ? di_s2[7:0] :
        (IO_ADDR == OFS_IN_HIGH)  ? di_s2[15:8] :
        BYTE_RST;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            IO_RDATA <= BYTE_RST;
        end else if (IO_RD) begin
            IO_RDATA <= rd_value;
        end
    end

    // ===============================
    // Checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    logic [7:0] since_fire;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) since_fire <= 8'hff;
        else if (pacer_fire) since_fire <= 8'h00;
        else if (since_fire != 8'hff) since_fire <= since_fire + 1'b1;
    end

    a_mode_write: assert property (
        wr_mode |=> conversion_mode_field == $past(IO_WDATA[2:0])
                 && interrupt_line_select == $past(IO_WDATA[6:4]))
        else $error("mode register not loaded");
    a_ext_start: assert property (
        m_ext && ext_rise && state == ST_IDLE && fifo_ready
        |=> ADC_START)
        else $error("external edge did not start");
    a_flag_hold: assert property (
        int_flag && !wr_int_clr |=> int_flag)
        else $error("flag dropped without clear");
    a_flag_clear: assert property (
        wr_int_clr && !(conv_end && m_int) |=> !int_flag ##1 IRQ_REQ == '0)
        else $error("clear write ignored");
    a_strobe_start: assert property (
        wr_strobe && state == ST_IDLE && fifo_ready |=> ADC_START)
        else $error("strobe did not start");
    a_input_read: assert property (
        IO_RD && IO_ADDR == OFS_IN_HIGH |=> IO_RDATA == $past(di_s2[15:8]))
        else $error("input high byte wrong");
    a_ao_staged: assert property (
        wr_ao_lo && !wr_ao_hi |=> $stable(ANALOG_OUT_CODE))
        else $error("analog output moved on low byte");
    a_ao_update: assert property (
        wr_ao_hi |=> ANALOG_OUT_CODE[11:8] == $past(IO_WDATA[3:0])
                  && ANALOG_OUT_CODE[7:0] == $past(ao_stage))
        else $error("analog code wrong");
    a_busy_flag: assert property (
        state != ST_IDLE |-> !result_pending_flag)
        else $error("ready during conversion");
    a_consume: assert property (
        rd_res_lo && fifo_level == LW'(1) && state == ST_IDLE
        |=> !result_pending_flag)
        else $error("low read did not consume");
    a_conv_bound: assert property (
        ADC_START |-> ##[2:160] state == ST_IDLE)
        else $error("conversion overran");
    a_pacer_gap: assert property (
        pacer_fire |-> since_fire >= 8'd30)
        else $error("pacer faster than base over four");
    a_irq_eoc: assert property (
        conv_end && m_int && interrupt_line_select == IRQ_SEL_4
        && !$changed(conversion_mode_field) |=> ##1 IRQ_REQ[2] || wr_mode)
        else $error("no request at end of conversion");
    a_irq_poll: assert property (
        !m_int |=> IRQ_REQ == '0)
        else $error("request in polling mode");
    a_high_zero: assert property (
        IO_RD && IO_ADDR == OFS_RES_HIGH |=> IO_RDATA[7:5] == 3'h0)
        else $error("high result byte upper bits set");
    a_unmapped: assert property (
        IO_RD && IO_ADDR == OFS_MODE |=> IO_RDATA == 8'h00)
        else $error("write-only offset read nonzero");

    c_sw_done: cover property (wr_strobe ##[1:200] result_pending_flag);
    c_ext_irq: cover property (m_ext && m_int && conv_end ##2 IRQ_REQ != '0);
    c_pacer: cover property (pacer_fire ##[1:400] pacer_fire);
    c_fifo_full: cover property (!fifo_ready);
endmodule

/* shared/acqcc_pkg.sv */
// Constants shared by the acquisition card control logic.
// Assumes a 20 MHz system clock and a byte-wide host I/O bus.
package acqcc_pkg;
    // ===============================
    // Clocking and timing
    localparam int CLK_HZ        = 20_000_000;
    localparam int CLK_NS        = 50;
    localparam int BASE_HZ       = 2_000_000;
    localparam int BASE_DIV      = CLK_HZ / BASE_HZ;
    localparam int CONV_MAX_NS   = 8000;
    localparam int CONV_MAX_CYC  = CONV_MAX_NS / CLK_NS;
    localparam int HOST_WAIT_NS  = 25000;
    localparam int PACER_MIN_DIV = 4;
    localparam int FIFO_DEPTH_D  = 32;

    // ===============================
    // Byte offsets within the 16-offset window
    localparam logic [3:0] OFS_RES_LOW  = 4'h4;
    localparam logic [3:0] OFS_RES_HIGH = 4'h5;
    localparam logic [3:0] OFS_AO_LOW   = 4'h4;
    localparam logic [3:0] OFS_AO_HIGH  = 4'h5;
    localparam logic [3:0] OFS_IN_LOW   = 4'h6;
    localparam logic [3:0] OFS_IN_HIGH  = 4'h7;
    localparam logic [3:0] OFS_INT_CLR  = 4'h8;
    localparam logic [3:0] OFS_MODE     = 4'hb;
    localparam logic [3:0] OFS_STROBE   = 4'hc;
    localparam logic [3:0] OFS_OUT_LOW  = 4'hd;
    localparam logic [3:0] OFS_OUT_HIGH = 4'he;

    // ===============================
    // Field positions and reset values
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 2;
    localparam int IRQ_LSB  = 4;
    localparam int IRQ_MSB  = 6;
    localparam int AO_HI_MSB = 3;
    localparam logic [2:0] MODE_RST = 3'h0;
    localparam logic [2:0] IRQ_RST  = 3'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] PACER_DIV_MIN = 16'h0002;

    // ===============================
    // Operating modes and interrupt line codes
    localparam logic [2:0] MODE_SW_POLL    = 3'h0;
    localparam logic [2:0] MODE_EXT_POLL   = 3'h2;
    localparam logic [2:0] MODE_EXT_INT    = 3'h3;
    localparam logic [2:0] MODE_PACER_POLL = 3'h4;
    localparam logic [2:0] MODE_PACER_INT  = 3'h6;
    localparam int IRQ_N = 5;
    localparam logic [2:0] IRQ_SEL_2A = 3'h0;
    localparam logic [2:0] IRQ_SEL_2B = 3'h2;
    localparam logic [2:0] IRQ_SEL_3  = 3'h3;
    localparam logic [2:0] IRQ_SEL_4  = 3'h4;
    localparam logic [2:0] IRQ_SEL_5  = 3'h5;
    localparam logic [2:0] IRQ_SEL_6  = 3'h6;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_WAIT  = 2'b10
    } acqcc_state_t;
endpackage

/* tb/acqcc_adc_model.sv */
// Behavioural converter on the far side of the control block.
// Assumes one-cycle start pulses on the system clock.
`timescale 1ns/100ps
module acqcc_adc_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Settings from the bench
    input  wire logic [7:0]  delay,
    input  wire logic [11:0] code,
    // Converter pins
    input  wire logic        start,
    output logic             eoc,
    output logic      [11:0] data
);
    logic [8:0] cnt;
    logic       busy;

    // ===============================
    // Data settles early; stale data is inverted after the hold
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            eoc  <= 1'b0;
            data <= 12'h000;
            cnt  <= 9'h000;
            busy <= 1'b0;
        end else if (start) begin
            busy <= 1'b1;
            eoc  <= 1'b0;
            cnt  <= 9'h000;
        end else begin
            cnt <= cnt + 9'h001;
            if (busy && cnt == 9'h001) begin
                data <= code;
            end
            if (busy && cnt == {1'b0, delay}) begin
                eoc  <= 1'b1;
                busy <= 1'b0;
            end
            if (!busy && eoc && cnt == {1'b0, delay} + 9'h006) begin
                data <= ~data;
            end
        end
    end
endmodule

/* tb/tb.sv */
// Self-checking bench for the acquisition card control block.
// Assumes the shared package and the behavioural converter model.
`timescale 1ns/100ps
module tb;
    import acqcc_pkg::*;
    // ===============================
    // Signals
    logic        clk_sys    = 1'b0;
    logic        rst_n      = 1'b0;
    logic [3:0]  io_addr    = 4'h0;
    logic        io_wr      = 1'b0;
    logic        io_rd      = 1'b0;
    logic [7:0]  io_wdata   = 8'h00;
    logic [15:0] in_lines   = 16'h0000;
    logic [15:0] div1       = 16'h0002;
    logic [15:0] div2       = 16'h0002;
    logic [7:0]  conv_delay = 8'h08;
    logic [11:0] conv_code  = 12'h5a3;
    logic [7:0]  io_rdata;
    logic [4:0]  irq_req;
    logic [15:0] out_lines;
    logic        adc_start;
    logic        adc_eoc;
    logic [11:0] adc_data;
    logic [11:0] ao_code;
    logic [4:0]  irq_map [0:7] = '{5'h01, 5'h00, 5'h01, 5'h02,
                                   5'h04, 5'h08, 5'h10, 5'h00};
    int          fail_count = 0;
    int          n_tests    = 0;

    // Clock
    always #25 clk_sys = ~clk_sys;

    acqcc_top #(.FIFO_DEPTH(32)) dut (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .IO_ADDR(io_addr),
        .IO_WR(io_wr), .IO_RD(io_rd), .IO_WDATA(io_wdata),
        .IO_RDATA(io_rdata), .IRQ_REQ(irq_req),
        .SAMPLED_INPUT_LINES(in_lines), .DRIVEN_OUTPUT_LINES(out_lines),
        .ADC_START(adc_start), .ADC_EOC(adc_eoc),
        .CONVERSION_RESULT(adc_data), .ANALOG_OUT_CODE(ao_code),
        .PACER_DIV1(div1), .PACER_DIV2(div2));

    acqcc_adc_model u_adc (
        .clk(clk_sys), .rst_n(rst_n), .delay(conv_delay),
        .code(conv_code), .start(adc_start), .eoc(adc_eoc),
        .data(adc_data));

    // ===============================
    // Bus cycles and helpers
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge clk_sys);
        io_wr <= 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge clk_sys);
        io_rd <= 1'b0;
        @(negedge clk_sys);
        d = io_rdata;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wait_start(input int lim, output int c);
        for (c = 0; c < lim && adc_start !== 1'b1; c++) @(negedge clk_sys);
    endtask

    task automatic drain(output int n);
        logic [7:0] b;
        n = 0;
        rd(OFS_RES_HIGH, b);
        while (b[4] === 1'b1 && n < 64) begin
            rd(OFS_RES_LOW, b);
            n++;
            rd(OFS_RES_HIGH, b);
        end
    endtask

    // ===============================
    // Scenarios
    task automatic t_reset;
        chk({3'h0, irq_req, io_rdata}, 16'h0000);
        chk(out_lines, 16'h0000);
        chk({3'h0, adc_start, ao_code}, 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_dio;
        logic [7:0] b;
        wr(OFS_OUT_LOW, 8'ha5);
        wr(OFS_OUT_HIGH, 8'h3c);
        chk(out_lines, 16'h3ca5);
        @(posedge clk_sys);
        in_lines <= 16'hb24e;
        repeat (3) @(posedge clk_sys);
        rd(OFS_IN_LOW, b);
        chk(b, 8'h4e);
        rd(OFS_IN_HIGH, b);
        chk(b, 8'hb2);
        rd(4'hf, b);
        chk(b, 8'h00);
        rd(OFS_MODE, b);
        chk(b, 8'h00);
        $display("test digital lines done");
    endtask

    task automatic t_dac;
        wr(OFS_AO_LOW, 8'h9c);
        chk(ao_code, 12'h000);
        wr(OFS_AO_HIGH, 8'hf7);
        chk(ao_code, 12'h79c);
        wr(OFS_AO_LOW, 8'h31);
        chk(ao_code, 12'h79c);
        wr(OFS_AO_HIGH, 8'h02);
        chk(ao_code, 12'h231);
        $display("test analog out done");
    endtask

    task automatic t_sw;
        logic [7:0] b;
        int c;
        wr(OFS_MODE, {5'h00, MODE_SW_POLL});
        @(posedge clk_sys);
        in_lines <= 16'hb24f;
        wait_start(10, c);
        chk(16'(c), 16'd10);
        conv_delay <= 8'h64;
        wr(OFS_STROBE, 8'h5a);
        wait_start(4, c);
        chk(16'(c), 16'd0);
        rd(OFS_RES_HIGH, b);
        chk(b[4], 1'b0);
        c = 0;
        do begin
            rd(OFS_RES_HIGH, b);
            c++;
        end while (b[4] !== 1'b1 && c < 100);
        chk(b, 8'h15);
        rd(OFS_RES_LOW, b);
        chk(b, 8'ha3);
        rd(OFS_RES_HIGH, b);
        chk(b[4], 1'b0);
        chk(irq_req, 5'h00);
        // Converter answers after 255 cycles: the 8 us limit must push the result
        conv_delay <= 8'hff;
        wr(OFS_STROBE, 8'h00);
        c = 0;
        do begin
            rd(OFS_RES_HIGH, b);
            c++;
        end while (b[4] !== 1'b1 && c < 100);
        chk(b, 8'h15);
        rd(OFS_RES_LOW, b);
        chk(b, 8'ha3);
        conv_delay <= 8'h08;
        $display("test software trigger done");
    endtask

    task automatic t_irq;
        int c;
        int n;
        for (int i = 0; i < 8; i++) begin
            wr(OFS_MODE, {1'b0, i[2:0], 1'b0, MODE_EXT_INT});
            @(posedge clk_sys);
            in_lines <= 16'hb24e;
            repeat (4) @(posedge clk_sys);
            in_lines <= 16'hb24f;
            wait_start(10, c);
            chk(adc_start, 1'b1);
            for (c = 0; c < 60 && irq_req === 5'h00; c++) @(negedge clk_sys);
            chk(irq_req, irq_map[i]);
            wr(OFS_STROBE, 8'h00);
            repeat (CONV_MAX_CYC) @(negedge clk_sys);
            chk(irq_req, irq_map[i]);
            wr(OFS_INT_CLR, 8'hff);
            @(negedge clk_sys);
            chk(irq_req, 5'h00);
            drain(n);
            chk(16'(n), 16'd2);
        end
        // External trigger with polling: starts, but never requests
        wr(OFS_MODE, {5'h00, MODE_EXT_POLL});
        @(posedge clk_sys);
        in_lines <= 16'hb24e;
        repeat (4) @(posedge clk_sys);
        in_lines <= 16'hb24f;
        wait_start(10, c);
        chk(adc_start, 1'b1);
        repeat (30) @(negedge clk_sys);
        chk(irq_req, 5'h00);
        drain(n);
        chk(16'(n), 16'd1);
        $display("test interrupt lines done");
    endtask

    task automatic t_pacer;
        int c;
        int n;
        wr(OFS_MODE, {5'h00, MODE_PACER_POLL});
        wait_start(100, c);
        @(negedge clk_sys);
        wait_start(100, c);
        chk(16'(c + 1), 16'(BASE_DIV * PACER_MIN_DIV));
        repeat (1400) @(negedge clk_sys);
        wait_start(100, c);
        chk(16'(c), 16'd100);
        wr(OFS_MODE, {5'h00, MODE_SW_POLL});
        repeat (20) @(negedge clk_sys);
        drain(n);
        chk(16'(n), 16'd32);
        wr(OFS_MODE, {4'h6, 1'b0, MODE_PACER_INT});
        for (c = 0; c < 100 && irq_req === 5'h00; c++) @(negedge clk_sys);
        chk(irq_req, 5'h10);
        wr(OFS_MODE, {5'h00, MODE_SW_POLL});
        @(negedge clk_sys);
        chk(irq_req, 5'h00);
        wr(OFS_INT_CLR, 8'h00);
        repeat (20) @(negedge clk_sys);
        drain(n);
        // Unequal divisors, the second below the floor of two
        @(posedge clk_sys);
        div1 <= 16'h0003;
        div2 <= 16'h0001;
        wr(OFS_MODE, {5'h00, MODE_PACER_POLL});
        wait_start(100, c);
        @(negedge clk_sys);
        wait_start(100, c);
        chk(16'(c + 1), 16'(BASE_DIV * 3 * 2));
        wr(OFS_MODE, {5'h00, MODE_SW_POLL});
        $display("test pacer done");
    endtask

    // ===============================
    // Verdict, sequence and watchdog
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(negedge clk_sys);
        t_reset;
        t_dio;
        t_dac;
        t_sw;
        t_irq;
        t_pacer;
        tally_and_finish;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish;
    end
endmodule
